// [shared/cfgcp_pkg.sv]
// Shared constants and types for the configuration control port
package cfgcp_pkg;
  localparam int FUNC_W   = 3;
  localparam int STAT_W   = 16;
  localparam int DSN_W    = 64;
  localparam int BUS_W    = 8;
  localparam int RID_W    = 16;
  localparam int CADDR_W  = 12;
  localparam int NFUNC    = 8;
  // Function select encoding
  localparam logic [FUNC_W-1:0] PF_LAST = 3'h1;
  // Byte addresses in configuration space; status in every function, DSN in function 0 only
  localparam logic [CADDR_W-1:0] DSN_CAP_BASE = 12'h100;
  localparam logic [CADDR_W-1:0] DSN_LO_OFS   = 12'h004;
  localparam logic [CADDR_W-1:0] DSN_HI_OFS   = 12'h008;
  localparam logic [CADDR_W-1:0] STAT_ADDR    = 12'h0C0;
  // Requester ID parts not driven by this port
  localparam logic [BUS_W-1:0] RID_DEVFN = 8'h00;
  localparam logic [BUS_W-1:0] UP_BUS_ID = 8'h00;
  // Completion status codes
  localparam logic [2:0] CPL_SC  = 3'h0;
  localparam logic [2:0] CPL_CRS = 3'h2;
  // APB register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_DSN_LO = 8'h08;
  localparam logic [7:0] REG_DSN_HI = 8'h0C;
  localparam logic [7:0] REG_STS    = 8'h10;
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_RDOUT  = 8'h18;
  localparam logic [7:0] REG_LIVE   = 8'h1C;
  // CTRL fields
  localparam int CTRL_HOTRST = 0;
  localparam int CTRL_ACCEPT = 1;
  localparam int CTRL_FUNC   = 8;
  localparam int CTRL_BUS    = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // CMD fields
  localparam int CMD_READ    = 0;
  localparam int CMD_REFRESH = 1;
  // STS and MASK fields
  localparam int STS_DONE   = 0;
  localparam int STS_HOTRST = 1;
  localparam int STS_W      = 2;
  localparam logic [STS_W-1:0] MASK_RST = 2'h0;
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_FETCH = 2'b01,
    RD_DONE  = 2'b10,
    RD_WAIT  = 2'b11
  } cfgcp_rd_t;
  typedef enum logic {
    HR_IDLE = 1'b0,
    HR_BUSY = 1'b1
  } cfgcp_hrd_t;
endpackage

// [shared/cfgcp_if.sv]
// Interface joining the core end and the user end of the port
`timescale 1ns/10ps
interface cfgcp_if;
  import cfgcp_pkg::*;
  logic              hot_reset_req;
  logic              hot_reset_ind;
  logic              cfg_space_accept;
  logic [FUNC_W-1:0] func_sel;
  logic              readout_req;
  logic              readout_done;
  logic [STAT_W-1:0] per_func_status;
  logic              per_func_vf;
  logic [DSN_W-1:0]  serial_number;
  logic              input_refresh;
  logic [BUS_W-1:0]  downstream_bus_id;
  modport core (
    input  hot_reset_req, cfg_space_accept, func_sel, readout_req,
    input  serial_number, input_refresh, downstream_bus_id,
    output hot_reset_ind, readout_done, per_func_status, per_func_vf
  );
  modport user (
    output hot_reset_req, cfg_space_accept, func_sel, readout_req,
    output serial_number, input_refresh, downstream_bus_id,
    input  hot_reset_ind, readout_done, per_func_status, per_func_vf
  );
endinterface

// [logic/cfgcp_core_end.sv]
// Core end of the configuration control port
// Contract
// - Root port: hot reset request drives LTSSM
// - Endpoint: hot reset indication reports entry
// - Endpoint, accept low: answer with CRS
// - User holds accept low during reload
// - User may tie accept high
// - Root port ignores accept input
// - Readout done pulses exactly one cycle
// - Select 0-1 are PFs, 2-7 VFs
// - Select plus request yields function values
// - Serial number halves land at 0x4, 0x8
// - User pulses refresh after serial stable
// - Downstream bus id used in internal RIDs; code uses it in root port mode only, endpoint uses UP_BUS_ID
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
module cfgcp_core_end
  import cfgcp_pkg::*;
(
  input  wire logic               CLK_I,
  input  wire logic               RSTN_I,
  input  wire logic               ROOT_PORT_MODE_I,
  input  wire logic               LINK_HOT_RESET_I,
  input  wire logic               CFG_REQ_VALID_I,
  input  wire logic               CFG_REQ_WRITE_I,
  input  wire logic [FUNC_W-1:0]  CFG_REQ_FUNC_I,
  input  wire logic [CADDR_W-1:0] CFG_REQ_ADDR_I,
  input  wire logic [31:0]        CFG_REQ_DATA_I,
  output logic                    CFG_CPL_VALID_O,
  output logic [2:0]              CFG_CPL_STATUS_O,
  output logic [31:0]             CFG_CPL_DATA_O,
  output logic                    LTSSM_HOT_RESET_O,
  input  wire logic               INT_TLP_REQ_I,
  output logic                    INT_TLP_VALID_O,
  output logic [RID_W-1:0]        INT_TLP_RID_O,
  cfgcp_if.core                   CTL
);

  // Hot reset group
  logic ltssm_hot;
  logic next_ltssm_hot;
  logic hot_ind;
  logic next_hot_ind;

  always_comb begin
    next_ltssm_hot = ROOT_PORT_MODE_I & CTL.hot_reset_req;
    next_hot_ind   = ~ROOT_PORT_MODE_I & LINK_HOT_RESET_I;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ltssm_hot <= 1'b0;
      hot_ind   <= 1'b0;
    end else begin
      ltssm_hot <= next_ltssm_hot;
      hot_ind   <= next_hot_ind;
    end
  end

  assign LTSSM_HOT_RESET_O = ltssm_hot;
  assign CTL.hot_reset_ind = hot_ind;

  // Serial number capture; only taken on refresh so a moving bus
  // never tears the two halves apart
  logic [31:0] dsn_lo;
  logic [31:0] dsn_hi;
  logic [31:0] next_dsn_lo;
  logic [31:0] next_dsn_hi;

  always_comb begin
    next_dsn_lo = dsn_lo;
    next_dsn_hi = dsn_hi;
    if (CTL.input_refresh) begin
      next_dsn_lo = CTL.serial_number[31:0];
      next_dsn_hi = CTL.serial_number[63:32];
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dsn_lo <= 32'h0000_0000;
      dsn_hi <= 32'h0000_0000;
    end else begin
      dsn_lo <= next_dsn_lo;
      dsn_hi <= next_dsn_hi;
    end
  end

  // Per-function status store and configuration completions
  logic [STAT_W-1:0] stat_mem [NFUNC];
  logic [STAT_W-1:0] next_stat_mem [NFUNC];
  logic              cpl_valid;
  logic              next_cpl_valid;
  logic [2:0]        cpl_status;
  logic [2:0]        next_cpl_status;
  logic [31:0]       cpl_data;
  logic [31:0]       next_cpl_data;
  logic              retry;

  // Root port never retries whatever accept says
  assign retry = ~ROOT_PORT_MODE_I & ~CTL.cfg_space_accept;

  always_comb begin
    next_stat_mem   = stat_mem;
    next_cpl_valid  = CFG_REQ_VALID_I;
    next_cpl_status = CPL_SC;
    next_cpl_data   = 32'h0000_0000;
    if (CFG_REQ_VALID_I) begin
      if (retry) begin
        next_cpl_status = CPL_CRS;
      end else if (CFG_REQ_WRITE_I) begin
        if (CFG_REQ_ADDR_I == STAT_ADDR) begin
          next_stat_mem[CFG_REQ_FUNC_I] = CFG_REQ_DATA_I[STAT_W-1:0];
        end
      end else if (CFG_REQ_ADDR_I == STAT_ADDR) begin
        next_cpl_data = {16'h0000, stat_mem[CFG_REQ_FUNC_I]};
      end else if (CFG_REQ_FUNC_I == 3'h0) begin
        if (CFG_REQ_ADDR_I == DSN_CAP_BASE + DSN_LO_OFS) begin
          next_cpl_data = dsn_lo;
        end else if (CFG_REQ_ADDR_I == DSN_CAP_BASE + DSN_HI_OFS) begin
          next_cpl_data = dsn_hi;
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < NFUNC; i++) begin
        stat_mem[i] <= 16'h0000;
      end
      cpl_valid  <= 1'b0;
      cpl_status <= 3'h0;
      cpl_data   <= 32'h0000_0000;
    end else begin
      stat_mem   <= next_stat_mem;
      cpl_valid  <= next_cpl_valid;
      cpl_status <= next_cpl_status;
      cpl_data   <= next_cpl_data;
    end
  end

  assign CFG_CPL_VALID_O  = cpl_valid;
  assign CFG_CPL_STATUS_O = cpl_status;
  assign CFG_CPL_DATA_O   = cpl_data;

  // Per-function readout
  cfgcp_rd_t         rd_state;
  cfgcp_rd_t         next_rd_state;
  logic [FUNC_W-1:0] rd_func;
  logic [FUNC_W-1:0] next_rd_func;
  logic [STAT_W-1:0] pf_out;
  logic [STAT_W-1:0] next_pf_out;
  logic              pf_vf;
  logic              next_pf_vf;

  always_comb begin
    next_rd_state = rd_state;
    next_rd_func  = rd_func;
    next_pf_out   = pf_out;
    next_pf_vf    = pf_vf;
    case (rd_state)
      RD_IDLE: begin
        if (CTL.readout_req) begin
          next_rd_func  = CTL.func_sel;
          next_rd_state = RD_FETCH;
        end
      end
      RD_FETCH: begin
        next_pf_out   = stat_mem[rd_func];
        next_pf_vf    = rd_func > PF_LAST;
        next_rd_state = RD_DONE;
      end
      RD_DONE: begin
        next_rd_state = RD_WAIT;
      end
      RD_WAIT: begin
        // A request still held would otherwise restart at once
        if (!CTL.readout_req) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_state <= RD_IDLE;
      rd_func  <= 3'h0;
      pf_out   <= 16'h0000;
      pf_vf    <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      rd_func  <= next_rd_func;
      pf_out   <= next_pf_out;
      pf_vf    <= next_pf_vf;
    end
  end

  assign CTL.readout_done    = rd_state == RD_DONE;
  assign CTL.per_func_status = pf_out;
  assign CTL.per_func_vf     = pf_vf;

  // Requester ID for internally generated TLPs
  logic             tlp_valid;
  logic             next_tlp_valid;
  logic [RID_W-1:0] tlp_rid;
  logic [RID_W-1:0] next_tlp_rid;

  always_comb begin
    next_tlp_valid = INT_TLP_REQ_I;
    next_tlp_rid   = tlp_rid;
    if (INT_TLP_REQ_I) begin
      if (ROOT_PORT_MODE_I) begin
        next_tlp_rid = {CTL.downstream_bus_id, RID_DEVFN};
      end else begin
        next_tlp_rid = {UP_BUS_ID, RID_DEVFN};
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tlp_valid <= 1'b0;
      tlp_rid   <= 16'h0000;
    end else begin
      tlp_valid <= next_tlp_valid;
      tlp_rid   <= next_tlp_rid;
    end
  end

  assign INT_TLP_VALID_O = tlp_valid;
  assign INT_TLP_RID_O   = tlp_rid;

endmodule

// [logic/cfgcp_user_end.sv]
// User end of the configuration control port with APB registers
`timescale 1ns/10ps
module cfgcp_user_end
  import cfgcp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  cfgcp_if.user            CTL
);

  logic wr;
  logic setup;
  logic mapped;

  assign wr    = PSEL_I & PENABLE_I & PWRITE_I;
  assign setup = PSEL_I & ~PENABLE_I;

  always_comb begin
    case (PADDR_I)
      REG_CTRL, REG_CMD, REG_DSN_LO, REG_DSN_HI,
      REG_STS, REG_MASK, REG_RDOUT, REG_LIVE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // Control registers; accept resets low so reload can finish first
  logic [31:0]      ctrl;
  logic [31:0]      next_ctrl;
  logic [31:0]      dlo;
  logic [31:0]      next_dlo;
  logic [31:0]      dhi;
  logic [31:0]      next_dhi;
  logic [STS_W-1:0] mask;
  logic [STS_W-1:0] next_mask;
  logic             refresh;
  logic             next_refresh;

  always_comb begin
    next_ctrl    = ctrl;
    next_dlo     = dlo;
    next_dhi     = dhi;
    next_mask    = mask;
    next_refresh = 1'b0;
    if (wr) begin
      case (PADDR_I)
        REG_CTRL:   next_ctrl = PWDATA_I;
        REG_DSN_LO: next_dlo = PWDATA_I;
        REG_DSN_HI: next_dhi = PWDATA_I;
        REG_MASK:   next_mask = PWDATA_I[STS_W-1:0];
        REG_CMD:    next_refresh = PWDATA_I[CMD_REFRESH];
        default:    next_refresh = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl    <= CTRL_RST;
      dlo     <= 32'h0000_0000;
      dhi     <= 32'h0000_0000;
      mask    <= MASK_RST;
      refresh <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      dlo     <= next_dlo;
      dhi     <= next_dhi;
      mask    <= next_mask;
      refresh <= next_refresh;
    end
  end

  assign CTL.hot_reset_req     = ctrl[CTRL_HOTRST];
  assign CTL.cfg_space_accept  = ctrl[CTRL_ACCEPT];
  assign CTL.downstream_bus_id = ctrl[CTRL_BUS +: BUS_W];
  assign CTL.serial_number     = {dhi, dlo};
  // Serial number is stable by the time the refresh pulse leaves
  assign CTL.input_refresh     = refresh;

  // Readout sequencer
  cfgcp_hrd_t        hr_state;
  cfgcp_hrd_t        next_hr_state;
  logic [FUNC_W-1:0] hr_func;
  logic [FUNC_W-1:0] next_hr_func;
  logic [STAT_W-1:0] res;
  logic [STAT_W-1:0] next_res;
  logic              res_vf;
  logic              next_res_vf;

  always_comb begin
    next_hr_state = hr_state;
    next_hr_func  = hr_func;
    next_res      = res;
    next_res_vf   = res_vf;
    case (hr_state)
      HR_IDLE: begin
        if (wr && PADDR_I == REG_CMD && PWDATA_I[CMD_READ]) begin
          next_hr_func  = ctrl[CTRL_FUNC +: FUNC_W];
          next_hr_state = HR_BUSY;
        end
      end
      HR_BUSY: begin
        if (CTL.readout_done) begin
          next_res      = CTL.per_func_status;
          next_res_vf   = CTL.per_func_vf;
          next_hr_state = HR_IDLE;
        end
      end
      default: begin
        next_hr_state = HR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hr_state <= HR_IDLE;
      hr_func  <= 3'h0;
      res      <= 16'h0000;
      res_vf   <= 1'b0;
    end else begin
      hr_state <= next_hr_state;
      hr_func  <= next_hr_func;
      res      <= next_res;
      res_vf   <= next_res_vf;
    end
  end

  assign CTL.readout_req = hr_state == HR_BUSY;
  assign CTL.func_sel    = hr_func;

  // Sticky status, read data; a read clears only what it reported
  logic [STS_W-1:0] sts;
  logic [STS_W-1:0] next_sts;
  logic [STS_W-1:0] shown;
  logic [STS_W-1:0] next_shown;
  logic [31:0]      rdata;
  logic [31:0]      next_rdata;
  logic             hot_d;
  logic [STS_W-1:0] ev;

  assign ev[STS_DONE]   = hr_state == HR_BUSY && CTL.readout_done;
  assign ev[STS_HOTRST] = CTL.hot_reset_ind & ~hot_d;

  always_comb begin
    next_shown = shown;
    next_rdata = rdata;
    next_sts   = sts;
    if (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == REG_STS) begin
      next_sts = sts & ~shown;
    end
    next_sts = next_sts | ev;
    if (setup) begin
      next_shown = 2'h0;
      case (PADDR_I)
        REG_CTRL:   next_rdata = ctrl;
        REG_DSN_LO: next_rdata = dlo;
        REG_DSN_HI: next_rdata = dhi;
        REG_STS: begin
          next_rdata = {30'h0000_0000, sts};
          next_shown = sts;
        end
        REG_MASK:   next_rdata = {30'h0000_0000, mask};
        REG_RDOUT:  next_rdata = {hr_state == HR_BUSY, 11'h000,
                                  res_vf, hr_func, res};
        REG_LIVE:   next_rdata = {31'h0000_0000, CTL.hot_reset_ind};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sts   <= 2'h0;
      shown <= 2'h0;
      rdata <= 32'h0000_0000;
      hot_d <= 1'b0;
    end else begin
      sts   <= next_sts;
      shown <= next_shown;
      rdata <= next_rdata;
      hot_d <= CTL.hot_reset_ind;
    end
  end

  assign PRDATA_O = rdata;
  assign IRQ_O    = |(sts & mask);

endmodule

// [tb/cfgcp_sva.sv]
// Concurrent checks on the signals between the two ends
`timescale 1ns/10ps
module cfgcp_sva
  import cfgcp_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              RSTN_I,
  input wire logic              readout_req,
  input wire logic              readout_done,
  input wire logic [FUNC_W-1:0] func_sel,
  input wire logic [STAT_W-1:0] per_func_status,
  input wire logic              per_func_vf,
  input wire logic [DSN_W-1:0]  serial_number,
  input wire logic              input_refresh
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  // Request held through fetch until done shows
  sequence s_fetch;
    readout_req [*2] ##[0:2] (readout_req && readout_done);
  endsequence
  sequence s_done_pulse;
    readout_done ##1 !readout_done;
  endsequence

  a_done_one_cycle: assert property (
    readout_done |-> s_done_pulse) else $error("done too wide");
  a_req_gets_done: assert property (
    $rose(readout_req) |-> s_fetch) else $error("readout too slow");
  a_done_has_req: assert property (
    readout_done |-> readout_req) else $error("done without request");
  a_done_drops_req: assert property (
    readout_done |=> !readout_req) else $error("request not released");
  a_vf_encoding: assert property (
    readout_done |-> per_func_vf == (func_sel > PF_LAST))
    else $error("function kind wrong");
  a_status_holds: assert property (
    !readout_req |=> $stable(per_func_status))
    else $error("status moved outside readout");
  a_refresh_pulse: assert property (
    input_refresh |=> !input_refresh) else $error("refresh too wide");
  a_serial_settled: assert property (
    input_refresh |-> $stable(serial_number))
    else $error("serial moving at refresh");
endmodule

// [tb/pcie_cfg_control_port_tb_top.sv]
// Self-checking bench joining both ends of the control port
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module pcie_cfg_control_port_tb_top;
  import cfgcp_pkg::*;
  logic               clk;
  logic               rst_n;
  logic               root_mode;
  logic               link_hr;
  logic               cq_valid;
  logic               cq_write;
  logic [FUNC_W-1:0]  cq_func;
  logic [CADDR_W-1:0] cq_addr;
  logic [31:0]        cq_data;
  logic               cpl_valid;
  logic [2:0]         cpl_status;
  logic [31:0]        cpl_data;
  logic               ltssm_hr;
  logic               it_req;
  logic               it_valid;
  logic [RID_W-1:0]   it_rid;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               irq;
  logic [31:0]        rd;
  logic               err;
  logic [2:0]         st;
  int                 fails = 0;
  int                 checked = 0;

  cfgcp_if cfgcp_if_i();
  cfgcp_core_end cfgcp_core_end_i (.CLK_I(clk), .RSTN_I(rst_n),
    .ROOT_PORT_MODE_I(root_mode), .LINK_HOT_RESET_I(link_hr),
    .CFG_REQ_VALID_I(cq_valid), .CFG_REQ_WRITE_I(cq_write),
    .CFG_REQ_FUNC_I(cq_func), .CFG_REQ_ADDR_I(cq_addr),
    .CFG_REQ_DATA_I(cq_data), .CFG_CPL_VALID_O(cpl_valid),
    .CFG_CPL_STATUS_O(cpl_status), .CFG_CPL_DATA_O(cpl_data),
    .LTSSM_HOT_RESET_O(ltssm_hr), .INT_TLP_REQ_I(it_req),
    .INT_TLP_VALID_O(it_valid), .INT_TLP_RID_O(it_rid), .CTL(cfgcp_if_i));
  cfgcp_user_end cfgcp_user_end_i (.CLK_I(clk), .RSTN_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
    .CTL(cfgcp_if_i));
  cfgcp_sva cfgcp_sva_i (.CLK_I(clk), .RSTN_I(rst_n),
    .readout_req(cfgcp_if_i.readout_req),
    .readout_done(cfgcp_if_i.readout_done),
    .func_sel(cfgcp_if_i.func_sel),
    .per_func_status(cfgcp_if_i.per_func_status),
    .per_func_vf(cfgcp_if_i.per_func_vf),
    .serial_number(cfgcp_if_i.serial_number),
    .input_refresh(cfgcp_if_i.input_refresh));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Read data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // No wait limit here; only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic cfg(input logic w, input logic [FUNC_W-1:0] f,
                     input logic [CADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    cq_valid <= 1'h1;
    cq_write <= w;
    cq_func <= f;
    cq_addr <= a;
    cq_data <= d;
    @(posedge clk);
    cq_valid <= 1'h0;
    @(negedge clk);
    `CHK(cpl_valid, 1'h1)
    st = cpl_status;
    rd = cpl_data;
  endtask

  task automatic tlp(input logic [RID_W-1:0] e);
    @(posedge clk);
    it_req <= 1'h1;
    @(posedge clk);
    it_req <= 1'h0;
    @(negedge clk);
    `CHK(it_valid, 1'h1)
    `CHK(it_rid, e)
  endtask

  task automatic t_regs;
    apb(1'h0, REG_CTRL, 32'h0);
    `CHK(rd, CTRL_RST)
    `CHK(pready, 1'h1)
    apb(1'h0, REG_MASK, 32'h0);
    `CHK(rd[STS_W-1:0], MASK_RST)
    apb(1'h1, 8'hF0, 32'hFFFF_FFFF);
    `CHK(err, 1'h1)
    apb(1'h0, 8'hF0, 32'h0);
    `CHK(err, 1'h1)
    `CHK(rd, 32'h0)
    $display("t_regs done");
  endtask

  task automatic t_crs;
    cfg(1'h1, 3'h0, STAT_ADDR, 32'h0000_1234);
    `CHK(st, CPL_CRS)
    apb(1'h1, REG_CTRL, 32'h1 << CTRL_ACCEPT);
    cfg(1'h0, 3'h0, STAT_ADDR, 32'h0);
    `CHK(st, CPL_SC)
    `CHK(rd, 32'h0)
    apb(1'h1, REG_CTRL, 32'h0);
    @(posedge clk);
    root_mode <= 1'h1;
    cfg(1'h0, 3'h0, STAT_ADDR, 32'h0);
    `CHK(st, CPL_SC)
    $display("t_crs done");
  endtask

  task automatic t_readout;
    logic [FUNC_W-1:0] f;
    int n;
    @(posedge clk);
    root_mode <= 1'h0;
    apb(1'h1, REG_CTRL, 32'h1 << CTRL_ACCEPT);
    apb(1'h1, REG_MASK, 32'h1);
    for (int i = 0; i < NFUNC; i++) begin
      cfg(1'h1, i[FUNC_W-1:0], STAT_ADDR, 32'h0000_A500 + i);
    end
    for (int i = NFUNC - 1; i >= 0; i--) begin
      f = i[FUNC_W-1:0];
      apb(1'h1, REG_CTRL, ({29'h0, f} << CTRL_FUNC) | 32'h2);
      apb(1'h1, REG_CMD, 32'h1);
      apb(1'h0, REG_RDOUT, 32'h0);
      `CHK(rd[31], 1'h1)
      n = 0;
      while (irq !== 1'h1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      `CHK(irq, 1'h1)
      apb(1'h0, REG_STS, 32'h0);
      `CHK(rd[STS_DONE], 1'h1)
      @(negedge clk);
      `CHK(irq, 1'h0)
      apb(1'h0, REG_RDOUT, 32'h0);
      `CHK(rd, {12'h0, f > PF_LAST, f, 16'hA500 | {13'h0, f}})
    end
    $display("t_readout done");
  endtask

  task automatic t_dsn;
    apb(1'h1, REG_DSN_LO, 32'h89AB_CDEF);
    apb(1'h1, REG_DSN_HI, 32'h0123_4567);
    cfg(1'h0, 3'h0, DSN_CAP_BASE + DSN_LO_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h1, REG_CMD, 32'h1 << CMD_REFRESH);
    cfg(1'h0, 3'h0, DSN_CAP_BASE + DSN_LO_OFS, 32'h0);
    `CHK(rd, 32'h89AB_CDEF)
    cfg(1'h0, 3'h0, DSN_CAP_BASE + DSN_HI_OFS, 32'h0);
    `CHK(rd, 32'h0123_4567)
    cfg(1'h0, 3'h1, DSN_CAP_BASE + DSN_LO_OFS, 32'h0);
    `CHK(rd, 32'h0)
    $display("t_dsn done");
  endtask

  task automatic t_bus_hot;
    @(posedge clk);
    root_mode <= 1'h1;
    apb(1'h1, REG_CTRL, 32'h00A5_0000);
    tlp({8'hA5, RID_DEVFN});
    apb(1'h1, REG_CTRL, 32'h00A5_0001);
    @(negedge clk);
    `CHK(ltssm_hr, 1'h0)
    @(negedge clk);
    `CHK(ltssm_hr, 1'h1)
    @(posedge clk);
    root_mode <= 1'h0;
    tlp({UP_BUS_ID, RID_DEVFN});
    apb(1'h1, REG_MASK, 32'h2);
    @(posedge clk);
    link_hr <= 1'h1;
    apb(1'h0, REG_LIVE, 32'h0);
    `CHK(rd[0], 1'h1)
    `CHK(irq, 1'h1)
    apb(1'h0, REG_STS, 32'h0);
    `CHK(rd[STS_HOTRST], 1'h1)
    link_hr <= 1'h0;
    $display("t_bus_hot done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    {rst_n, root_mode, link_hr, cq_valid, cq_write, it_req} = 6'h0;
    {psel, penable, pwrite, cq_func, cq_addr} = 18'h0;
    {paddr, pwdata, cq_data} = 72'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_crs();
    t_readout();
    t_dsn();
    t_bus_hot();
    wrap_up();
  end
endmodule
